// ===== timer16_cfg.svh
// register map, field positions, reset values and prescaler taps
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

`define OFS_CTRL_A        8'h00
`define OFS_CTRL_B        8'h04
`define OFS_COUNT_LOW     8'h08
`define OFS_COUNT_HIGH    8'h0C
`define OFS_CMP_A_LOW     8'h10
`define OFS_CMP_A_HIGH    8'h14
`define OFS_CMP_B_LOW     8'h18
`define OFS_CMP_B_HIGH    8'h1C
`define OFS_FLAGS         8'h20
`define OFS_POWER         8'h24

`define CTRL_A_WGM_LSB    0
`define CTRL_B_SEL_LSB    0
`define CTRL_B_WGM_LSB    3
`define CTRL_A_MASK       8'h03
`define CTRL_B_MASK       8'h1F
`define FLAG_OVF_BIT      0
`define POWER_GATE_BIT    0
`define POWER_PRESC_BIT   1

`define RST_CTRL          8'h00
`define RST_COUNT         16'h0000
`define RST_CMP           16'h0000

`define TAP_DIV8          10'h007
`define TAP_DIV64         10'h03F
`define TAP_DIV256        10'h0FF
`define TAP_DIV1024       10'h3FF

`define TOP_8BIT          16'h00FF
`define TOP_9BIT          16'h01FF
`define TOP_10BIT         16'h03FF
`define TOP_MAX           16'hFFFF

`endif

// ===== timer16_pkg.sv
// shared types of the timer clock and counter block
package timer16_pkg;

	typedef logic [7:0]  byte_t;
	typedef logic [15:0] word_t;

	typedef enum logic [2:0] {
		SRC_STOP     = 3'h0,
		SRC_DIRECT   = 3'h1,
		SRC_DIV8     = 3'h2,
		SRC_DIV64    = 3'h3,
		SRC_DIV256   = 3'h4,
		SRC_DIV1024  = 3'h5,
		SRC_PIN_FALL = 3'h6,
		SRC_PIN_RISE = 3'h7
	} tick_source_e;

	typedef enum logic [1:0] {
		KIND_NORMAL    = 2'h0,
		KIND_CLEAR_TOP = 2'h1,
		KIND_FAST      = 2'h2,
		KIND_PHASE     = 2'h3
	} count_kind_e;

endpackage : timer16_pkg

// ===== pin_edge_detect.sv
// three-stage pin synchroniser with rise and fall edge pulses
`timescale 1ns/10ps

module pin_edge_detect (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);

	logic sync1_ff;
	logic sync2_ff;
	logic sync3_ff;
	logic level_ff;
	logic agree;
	logic nxt_level;

	// a change counts only once the second and third stages agree
	assign agree     = (sync2_ff == sync3_ff);
	assign nxt_level = agree ? sync3_ff : level_ff;
	assign rise_o    = agree & sync3_ff & ~level_ff;
	assign fall_o    = agree & ~sync3_ff & level_ff;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			sync3_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			sync1_ff <= pin_i;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			level_ff <= nxt_level;
		end
	end

	ext_latency_a: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		!pin_i [*3] ##1 pin_i [*3] |=> rise_o)
		else $error("pin edge not seen three cycles later");

endmodule : pin_edge_detect

// ===== timer16_clock_and_counter.sv
// timer tick selection, shared prescaler and 16-bit counter with bus access
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "timer16_cfg.svh"
module timer16_clock_and_counter #(
	parameter int ADR_W   = 8,
	parameter int PRESC_W = 10
) (
	input  wire logic                sys_clk_i,
	input  wire logic                rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [ADR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                external_count_pin_i,
	input  wire logic                prescaler_reset_i,
	output timer16_pkg::word_t       count_value_o,
	output logic                     count_top_o,
	output logic                     count_bottom_o,
	output logic                     count_down_o,
	output logic                     timer_tick_o,
	output logic                     overflow_flag_o
);
	import timer16_pkg::*;

	function automatic logic tap_hit(input logic [PRESC_W-1:0] cnt,
	                                 input logic [PRESC_W-1:0] mask);
		tap_hit = ((cnt & mask) == mask);
	endfunction : tap_hit
	function automatic count_kind_e kind_of(input logic [3:0] wgm);
		unique case (wgm)
			4'h0, 4'hD:                    kind_of = KIND_NORMAL;
			4'h4, 4'hC:                    kind_of = KIND_CLEAR_TOP;
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF:  kind_of = KIND_FAST;
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
			4'hA, 4'hB:                    kind_of = KIND_PHASE;
		endcase
	endfunction : kind_of
	// modes that would take top from capture use compare A instead
	function automatic word_t top_of(input logic [3:0] wgm,
	                                 input word_t cmp);
		unique case (wgm)
			4'h1, 4'h5: top_of = `TOP_8BIT;
			4'h2, 4'h6: top_of = `TOP_9BIT;
			4'h3, 4'h7: top_of = `TOP_10BIT;
			4'h0, 4'hD: top_of = `TOP_MAX;
			4'h4, 4'h8, 4'h9, 4'hA, 4'hB,
			4'hC, 4'hE, 4'hF: top_of = cmp;
		endcase
	endfunction : top_of
	byte_t               ctrl_a_ff;
	byte_t               ctrl_b_ff;
	word_t               count_ff;
	byte_t               hold_high_ff;
	word_t               cmp_a_ff;
	word_t               cmp_b_ff;
	logic                ovf_ff;
	logic                gate_ff;
	logic [PRESC_W-1:0]  presc_ff;
	logic                down_ff;
	logic                ack_ff;
	logic [31:0]         rdata_ff;
	logic                top_ff;
	logic                bottom_ff;
	logic                tick_ff;
	logic                req;
	logic                wr_lane;
	logic                rd;
	byte_t               wbyte;
	logic                hit_ctrl_a;
	logic                hit_ctrl_b;
	logic                hit_cnt_lo;
	logic                hit_cnt_hi;
	logic                hit_cmpa_lo;
	logic                hit_cmpa_hi;
	logic                hit_cmpb_lo;
	logic                hit_cmpb_hi;
	logic                hit_flags;
	logic                hit_power;
	logic                wr_open;
	logic                wr_ctrl_a;
	logic                wr_ctrl_b;
	logic                wr_cnt_lo;
	logic                wr_high;
	logic                wr_cmpa_lo;
	logic                wr_cmpb_lo;
	logic                wr_flags;
	logic                wr_power;
	logic                rd_cnt_lo;
	byte_t               rd_byte;
	byte_t               nxt_hold_high;
	tick_source_e        src;
	logic [3:0]          wgm;
	count_kind_e         kind;
	word_t               top_val;
	logic                presc_clear;
	logic [PRESC_W-1:0]  nxt_presc;
	logic                pin_rise;
	logic                pin_fall;
	logic                raw_tick;
	logic                tick;
	word_t               count_up;
	word_t               count_dn;
	logic                at_top;
	logic                at_zero;
	word_t               nxt_count;
	logic                nxt_down;
	logic                ovf_set;
	logic                nxt_ovf;
	// bus decode: one action per request, taken in the cycle before ack
	assign req         = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_lane     = req & wb_we_i & wb_sel_i[0];
	assign rd          = req & ~wb_we_i;
	assign wbyte       = wb_dat_i[7:0];
	assign hit_ctrl_a  = (wb_adr_i == `OFS_CTRL_A);
	assign hit_ctrl_b  = (wb_adr_i == `OFS_CTRL_B);
	assign hit_cnt_lo  = (wb_adr_i == `OFS_COUNT_LOW);
	assign hit_cnt_hi  = (wb_adr_i == `OFS_COUNT_HIGH);
	assign hit_cmpa_lo = (wb_adr_i == `OFS_CMP_A_LOW);
	assign hit_cmpa_hi = (wb_adr_i == `OFS_CMP_A_HIGH);
	assign hit_cmpb_lo = (wb_adr_i == `OFS_CMP_B_LOW);
	assign hit_cmpb_hi = (wb_adr_i == `OFS_CMP_B_HIGH);
	assign hit_flags   = (wb_adr_i == `OFS_FLAGS);
	assign hit_power   = (wb_adr_i == `OFS_POWER);

	// while gated only the power register accepts writes
	assign wr_open    = wr_lane & ~gate_ff;
	assign wr_ctrl_a  = wr_open & hit_ctrl_a;
	assign wr_ctrl_b  = wr_open & hit_ctrl_b;
	assign wr_cnt_lo  = wr_open & hit_cnt_lo;
	assign wr_high    = wr_open & (hit_cnt_hi | hit_cmpa_hi | hit_cmpb_hi);
	assign wr_cmpa_lo = wr_open & hit_cmpa_lo;
	assign wr_cmpb_lo = wr_open & hit_cmpb_lo;
	assign wr_flags   = wr_open & hit_flags;
	assign wr_power   = wr_lane & hit_power;
	assign rd_cnt_lo  = rd & hit_cnt_lo;

	assign nxt_hold_high = wr_high   ? wbyte :
	                       rd_cnt_lo ? count_ff[15:8] :
	                                   hold_high_ff;

	// compare highs read directly; only the counter high uses the latch
	assign rd_byte =
		hit_ctrl_a  ? ctrl_a_ff :
		hit_ctrl_b  ? ctrl_b_ff :
		hit_cnt_lo  ? count_ff[7:0] :
		hit_cnt_hi  ? hold_high_ff :
		hit_cmpa_lo ? cmp_a_ff[7:0] :
		hit_cmpa_hi ? cmp_a_ff[15:8] :
		hit_cmpb_lo ? cmp_b_ff[7:0] :
		hit_cmpb_hi ? cmp_b_ff[15:8] :
		hit_flags   ? {7'h00, ovf_ff} :
		hit_power   ? {7'h00, gate_ff} : 8'h00;

	// tick selection and the shared free-running prescaler
	assign src  = tick_source_e'(ctrl_b_ff[`CTRL_B_SEL_LSB +: 3]);
	assign wgm  = {ctrl_b_ff[`CTRL_B_WGM_LSB +: 2],
	               ctrl_a_ff[`CTRL_A_WGM_LSB +: 2]};
	assign kind    = kind_of(wgm);
	assign top_val = top_of(wgm, cmp_a_ff);

	// a clear here realigns the taps of every timer sharing them
	assign presc_clear = prescaler_reset_i |
	                     (wr_power & wbyte[`POWER_PRESC_BIT]);
	assign nxt_presc   = presc_clear ? '0 :
	                     PRESC_W'(presc_ff + 1'b1);

	pin_edge_detect u_pin_edge (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.pin_i     (external_count_pin_i),
		.rise_o    (pin_rise),
		.fall_o    (pin_fall)
	);
	always_comb begin
		unique case (src)
			SRC_STOP:     raw_tick = 1'b0;
			SRC_DIRECT:   raw_tick = 1'b1;
			SRC_DIV8:     raw_tick = tap_hit(presc_ff, `TAP_DIV8);
			SRC_DIV64:    raw_tick = tap_hit(presc_ff, `TAP_DIV64);
			SRC_DIV256:   raw_tick = tap_hit(presc_ff, `TAP_DIV256);
			SRC_DIV1024:  raw_tick = tap_hit(presc_ff, `TAP_DIV1024);
			SRC_PIN_FALL: raw_tick = pin_fall;
			SRC_PIN_RISE: raw_tick = pin_rise;
		endcase
	end

	assign tick = raw_tick & ~gate_ff;
	// counter core
	assign count_up = 16'(count_ff + 16'h0001);
	assign count_dn = 16'(count_ff - 16'h0001);
	assign at_top   = (count_ff == top_val);
	assign at_zero  = (count_ff == 16'h0000);
	always_comb begin
		nxt_count = count_ff;
		nxt_down  = down_ff;
		ovf_set   = 1'b0;
		if (tick) begin
			unique case (kind)
				KIND_NORMAL: begin
					nxt_count = count_up;
					nxt_down  = 1'b0;
					ovf_set   = (count_ff == `TOP_MAX);
				end
				KIND_CLEAR_TOP: begin
					nxt_count = at_top ? 16'h0000 : count_up;
					nxt_down  = 1'b0;
					ovf_set   = (count_ff == `TOP_MAX);
				end
				KIND_FAST: begin
					nxt_count = at_top ? 16'h0000 : count_up;
					nxt_down  = 1'b0;
					ovf_set   = at_top;
				end
				KIND_PHASE: begin
					if (!down_ff) begin
						nxt_down  = (count_ff >= top_val);
						nxt_count = nxt_down ? count_dn : count_up;
					end else if (at_zero) begin
						nxt_down  = 1'b0;
						nxt_count = count_up;
						ovf_set   = 1'b1;
					end else begin
						nxt_count = count_dn;
					end
				end
			endcase
		end
		// a bus write overrides any count or clear in the same cycle
		if (wr_cnt_lo) begin
			nxt_count = {hold_high_ff, wbyte};
		end
	end

	// the set wins over a clear in the same cycle
	assign nxt_ovf = ovf_set |
	                 (ovf_ff & ~(wr_flags & wbyte[`FLAG_OVF_BIT]));
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl_a_ff    <= `RST_CTRL;
			ctrl_b_ff    <= `RST_CTRL;
			cmp_a_ff     <= `RST_CMP;
			cmp_b_ff     <= `RST_CMP;
			gate_ff      <= 1'b0;
			hold_high_ff <= 8'h00;
			ack_ff       <= 1'b0;
			rdata_ff     <= 32'h0000_0000;
		end else begin
			if (wr_ctrl_a) ctrl_a_ff <= wbyte & `CTRL_A_MASK;
			if (wr_ctrl_b) ctrl_b_ff <= wbyte & `CTRL_B_MASK;
			if (wr_cmpa_lo) cmp_a_ff <= {hold_high_ff, wbyte};
			if (wr_cmpb_lo) cmp_b_ff <= {hold_high_ff, wbyte};
			if (wr_power) gate_ff <= wbyte[`POWER_GATE_BIT];
			hold_high_ff <= nxt_hold_high;
			ack_ff       <= req;
			if (rd) rdata_ff <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			count_ff  <= `RST_COUNT;
			down_ff   <= 1'b0;
			ovf_ff    <= 1'b0;
			presc_ff  <= '0;
			top_ff    <= 1'b0;
			bottom_ff <= 1'b1;
			tick_ff   <= 1'b0;
		end else begin
			count_ff  <= nxt_count;
			down_ff   <= nxt_down;
			ovf_ff    <= nxt_ovf;
			presc_ff  <= nxt_presc;
			top_ff    <= (nxt_count == top_val);
			bottom_ff <= (nxt_count == 16'h0000);
			tick_ff   <= tick;
		end
	end

	assign wb_ack_o        = ack_ff;
	assign wb_dat_o        = rdata_ff;
	assign count_value_o   = count_ff;
	assign count_top_o     = top_ff;
	assign count_bottom_o  = bottom_ff;
	assign count_down_o    = down_ff;
	assign timer_tick_o    = tick_ff;
	assign overflow_flag_o = ovf_ff;
	default clocking dflt_cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	direct_tick_a: assert property (
		src == SRC_DIRECT && kind == KIND_NORMAL && !gate_ff && !wr_cnt_lo
		|=> count_ff == 16'($past(count_ff) + 16'h0001))
		else $error("direct source did not count every clock");
	tap_align_a: assert property (
		raw_tick && src == SRC_DIV64 |-> presc_ff[5:0] == 6'h3F)
		else $error("divide by 64 tick off its tap");
	// the edge that releases reset still clears, so it is skipped
	free_run_a: assert property (
		!rst_i && !presc_clear
		|=> presc_ff == PRESC_W'($past(presc_ff) + 1'b1))
		else $error("prescaler did not run freely");
	presc_clear_a: assert property (
		presc_clear ##1 !presc_clear [*7]
		|=> tap_hit(presc_ff, `TAP_DIV8))
		else $error("prescaler reset did not restart the period");
	pin_fall_a: assert property (
		pin_fall && src == SRC_PIN_FALL && kind == KIND_NORMAL && !gate_ff
		&& !wr_cnt_lo |=> count_ff == 16'($past(count_ff) + 16'h0001))
		else $error("falling pin edge did not count once");
	stop_hold_a: assert property (
		src == SRC_STOP && !wr_cnt_lo |=> $stable(count_ff))
		else $error("stopped counter moved");
	cpu_write_a: assert property (
		wr_cnt_lo |=> count_ff == {$past(hold_high_ff), $past(wbyte)})
		else $error("bus write lost to count or clear");
	latch_copy_a: assert property (
		rd_cnt_lo |=> hold_high_ff == $past(count_ff[15:8]))
		else $error("low read did not copy the high byte");
	latch_keep_a: assert property (
		wr_cnt_lo |=> $stable(hold_high_ff))
		else $error("high latch changed on low write");
	bottom_flag_a: assert property (
		bottom_ff == (count_ff == 16'h0000))
		else $error("bottom indication disagrees with count");
	gate_hold_a: assert property (
		gate_ff |=> $stable(count_ff) && $stable(ctrl_b_ff))
		else $error("gated timer changed state");
	ovf_sticky_a: assert property (
		ovf_ff && !wr_flags |=> ovf_ff)
		else $error("overflow flag dropped without a clear");
	pin_tick_c: cover property (src == SRC_PIN_RISE && tick);
	ovf_set_c: cover property (ovf_set && !ovf_ff);
	phase_turn_c: cover property (kind == KIND_PHASE && !down_ff ##1 down_ff);
	slow_tap_c: cover property (src == SRC_DIV1024 && tick);

endmodule : timer16_clock_and_counter

// ===== cpu_bus_model.sv
// processor-side master issuing single classic Wishbone cycles
`timescale 1ns/10ps

module cpu_bus_model (
	input  wire logic        sys_clk_i,
	input  wire logic        wb_ack_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic [7:0]       wb_adr_o,
	output logic [3:0]       wb_sel_o,
	output logic [31:0]      wb_dat_o
);
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o  = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0000_0000;
	end

	// set_cnt issues its byte pair back to back, never split by other code
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= w;
		wb_adr_o <= a;
		wb_sel_o <= 4'h1;
		wb_dat_o <= {24'h00_0000, d};
		do begin
			@(posedge sys_clk_i);
		end while (wb_ack_i !== 1'b1);
		q = wb_dat_i[7:0];
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o  <= 1'b0;
		// released lines must not look like a held request
		wb_adr_o <= ~a;
		wb_dat_o <= ~{24'h00_0000, d};
	endtask : xfer
endmodule : cpu_bus_model

// ===== tb.sv
// self-checking bench for the timer clock and counter block
`timescale 1ns/10ps
`include "timer16_cfg.svh"

module tb;
	import timer16_pkg::*;

	typedef struct packed {
		logic [7:0] adr;
		logic [7:0] wdat;
		logic [7:0] exp;
	} row_s;

	logic        sys_clk;
	logic        rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        pin;
	logic        psc_rst;
	word_t       cnt;
	logic        top;
	logic        bot;
	logic        down;
	logic        tick;
	logic        ovf;
	int          num_errors;
	int          checked;
	int          cycles;
	int          i;
	int          n;
	logic [15:0] c0;
	logic [7:0]  q;
	int          div [4] = '{8, 64, 256, 1024};
	row_s        rows [9] = '{
		'{`OFS_COUNT_HIGH, 8'hA5, 8'hA5},
		'{`OFS_CMP_A_HIGH, 8'h12, 8'h00},
		'{`OFS_CMP_A_LOW,  8'h34, 8'h34},
		'{`OFS_CTRL_A,     8'hFF, 8'h03},
		'{`OFS_CTRL_B,     8'hF8, 8'h18},
		'{`OFS_FLAGS,      8'h01, 8'h00},
		'{`OFS_POWER,      8'h02, 8'h00},
		'{8'h28,           8'h55, 8'h00},
		'{`OFS_CTRL_A,     8'h00, 8'h00}
	};

	timer16_clock_and_counter u_timer16_clock_and_counter (
		.sys_clk_i(sys_clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .external_count_pin_i(pin),
		.prescaler_reset_i(psc_rst), .count_value_o(cnt),
		.count_top_o(top), .count_bottom_o(bot), .count_down_o(down),
		.timer_tick_o(tick), .overflow_flag_o(ovf)
	);

	cpu_bus_model u_cpu_bus_model (
		.sys_clk_i(sys_clk), .wb_ack_i(ack), .wb_dat_i(rdat),
		.wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
		.wb_sel_o(sel), .wb_dat_o(wdat)
	);

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		u_cpu_bus_model.xfer(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		u_cpu_bus_model.xfer(1'b0, a, 8'h00, r);
	endtask : rd

	// high byte first so the latch holds it when the low byte lands
	task automatic set_cnt(input logic [15:0] v);
		wr(`OFS_COUNT_HIGH, v[15:8]);
		wr(`OFS_COUNT_LOW, v[7:0]);
	endtask : set_cnt

	task automatic cyc_wait(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : cyc_wait

	task automatic pin_to(input logic v);
		@(posedge sys_clk);
		pin <= v;
	endtask : pin_to

	task final_report;
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			final_report();
		end
	end

	initial begin
		rst = 1'b1;
		pin = 1'b0;
		psc_rst = 1'b0;
		num_errors = 0;
		checked = 0;
		cycles = 0;
		cyc_wait(8);
		rst <= 1'b0;
		cyc_wait(2);
		chk("reset count", 16'h0000, cnt);
		chk("reset flags", 16'h0001, {11'h0, ack, tick, ovf, top, bot});
		for (i = 0; i < 9; i++) begin
			wr(rows[i].adr, rows[i].wdat);
			rd(rows[i].adr, q);
			chk("register row", {8'h00, rows[i].exp}, {8'h00, q});
		end
		rd(`OFS_CMP_A_HIGH, q);
		chk("compare high", 16'h0012, {8'h00, q});
		wr(`OFS_CTRL_B, 8'h00);
		// stopped counter stays reachable over the bus
		set_cnt(16'h1234);
		chk("loaded count", 16'h1234, cnt);
		wr(`OFS_COUNT_LOW, 8'h56);
		chk("latch reuse", 16'h1256, cnt);
		cyc_wait(10);
		chk("stopped", 16'h1256, cnt);
		chk("no tick", 16'h0000, {15'h0, tick});
		rd(`OFS_COUNT_LOW, q);
		chk("low read", 16'h0056, {8'h00, q});
		rd(`OFS_COUNT_HIGH, q);
		chk("high read", 16'h0012, {8'h00, q});
		wr(`OFS_CTRL_B, 8'h01);
		set_cnt(16'hABCD);
		chk("write priority", 16'hABCD, cnt);
		cyc_wait(1);
		chk("direct tick", 16'hABCE, cnt);
		chk("tick pulse", 16'h0001, {15'h0, tick});
		cyc_wait(10);
		chk("direct ten", 16'hABD8, cnt);
		wr(`OFS_POWER, 8'h01);
		c0 = cnt;
		set_cnt(16'h0000);
		chk("gated", c0, cnt);
		wr(`OFS_POWER, 8'h00);
		cyc_wait(3);
		chk("ungated", 16'h0001, 16'(cnt !== c0));
		for (i = 0; i < 4; i++) begin
			wr(`OFS_CTRL_B, 8'h00);
			wr(`OFS_CTRL_B, 8'(i + 2));
			c0 = cnt;
			n = 0;
			while (cnt === c0 && n <= div[i] + 2) begin
				@(posedge sys_clk);
				n++;
			end
			chk("first tick", 16'h0001, 16'(n <= div[i] + 1));
			c0 = cnt;
			cyc_wait(3 * div[i]);
			chk("prescaled", c0 + 16'd3, cnt);
		end
		// divide by 8, so the realigned first tick comes soon
		wr(`OFS_CTRL_B, 8'h02);
		@(posedge sys_clk);
		psc_rst <= 1'b1;
		// a tap may still fire on the edge that first sees the reset
		cyc_wait(2);
		c0 = cnt;
		cyc_wait(18);
		chk("held prescaler", c0, cnt);
		psc_rst <= 1'b0;
		n = 0;
		while (cnt === c0 && n < 12) begin
			@(posedge sys_clk);
			n++;
		end
		chk("realigned", 16'h0001, 16'(n == 9));
		for (i = 0; i < 2; i++) begin
			wr(`OFS_CTRL_B, 8'h00);
			set_cnt(16'h0000);
			// pin settles before the source is switched
			pin_to(i[0]);
			cyc_wait(4);
			wr(`OFS_CTRL_B, i == 0 ? 8'h07 : 8'h06);
			repeat (3) begin
				c0 = cnt;
				// seven-cycle half periods keep each level sampled
				pin_to(~pin);
				cyc_wait(3);
				chk("pin early", c0, cnt);
				cyc_wait(3);
				chk("pin edge", c0 + 16'd1, cnt);
				pin_to(~pin);
				cyc_wait(6);
				chk("other edge", c0 + 16'd1, cnt);
			end
		end
		wr(`OFS_CTRL_B, 8'h00);
		set_cnt(16'hFFFF);
		cyc_wait(2);
		chk("top mark", 16'h0002, {14'h0, top, bot});
		set_cnt(16'h0000);
		cyc_wait(2);
		chk("bottom mark", 16'h0001, {14'h0, top, bot});
		set_cnt(16'hFFFD);
		wr(`OFS_CTRL_B, 8'h01);
		wr(`OFS_CTRL_B, 8'h00);
		chk("overflow", 16'h0001, {15'h0, ovf});
		rd(`OFS_FLAGS, q);
		chk("flag read", 16'h0001, {8'h00, q});
		wr(`OFS_FLAGS, 8'h01);
		chk("flag clear", 16'h0000, {15'h0, ovf});
		wr(`OFS_CTRL_A, 8'h01);
		set_cnt(16'h00FD);
		wr(`OFS_CTRL_B, 8'h01);
		cyc_wait(8);
		c0 = cnt;
		cyc_wait(1);
		chk("count down", c0 - 16'd1, cnt);
		chk("down flag", 16'h0001, {15'h0, down});
		wr(`OFS_CTRL_B, 8'h00);
		wr(`OFS_FLAGS, 8'h01);
		set_cnt(16'h00FD);
		wr(`OFS_CTRL_B, 8'h09);
		n = 0;
		while (cnt !== 16'h0000 && n < 10) begin
			@(posedge sys_clk);
			n++;
		end
		chk("fast wrap", 16'h0000, cnt);
		chk("fast ovf", 16'h0001, {15'h0, ovf});
		wr(`OFS_CTRL_B, 8'h00);
		final_report();
	end
endmodule : tb
